// File: rtl/ief_pkg.sv
// Constants, field positions and register offsets of the interrupt-enable and status-flag block.
// Assumes a 32-bit Avalon-MM register bus and a bus engine on the same clock.
package ief_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] IEF_OFS_CTRL = 5'h00;
    localparam logic [4:0] IEF_OFS_FLAGS = 5'h04;
    localparam logic [4:0] IEF_OFS_TXBUF = 5'h08;
    localparam logic [4:0] IEF_OFS_RXBUF = 5'h0c;
    localparam logic [4:0] IEF_OFS_ISTAT = 5'h10;
    localparam logic [4:0] IEF_OFS_ICLR = 5'h14;
    localparam logic [4:0] IEF_OFS_IEN = 5'h18;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IEF_B_TIE = 7;
    localparam int IEF_B_TX_DONE_IRQ_EN = 6;
    localparam int IEF_B_RIE = 5;
    localparam int IEF_B_NACK_IRQ_EN = 4;
    localparam int IEF_B_STOP_IRQ_EN = 3;
    localparam int IEF_B_ACK_JUDGE_SELECT = 2;
    localparam int IEF_B_RX_ACK_BIT = 1;
    localparam int IEF_B_TX_ACK_BIT = 0;
    localparam int IEF_B_TX_BUFFER_EMPTY = 7;
    localparam int IEF_B_TRANSMIT_END = 6;
    localparam int IEF_B_RX_BUFFER_FULL = 5;
    localparam int IEF_B_NO_ACK_FLAG = 4;
    localparam int IEF_B_STOPF = 3;
    localparam int IEF_B_ALOVE = 2;
    // Request indices in the interrupt status, clear and enable registers.
    localparam int IEF_RQ_TXE = 0;
    localparam int IEF_RQ_TXD = 1;
    localparam int IEF_RQ_RXF = 2;
    localparam int IEF_RQ_OVR = 3;
    localparam int IEF_RQ_NAK = 4;
    localparam int IEF_RQ_STP = 5;
    localparam int IEF_NREQ = 6;
    // ------------------------------------------------------------------
    // Reset values and link counts
    // ------------------------------------------------------------------
    localparam logic [7:0] IEF_RST_BYTE = 8'h00;
    localparam logic [3:0] IEF_ACK_FALLS = 4'h8;
    localparam logic [3:0] IEF_LAST_RISES = 4'h8;
endpackage : ief_pkg

// File: rtl/ief_link_if.sv
// Link-side events passed from the serial clock edge finder to the flag logic.
// Assumes both ends run on the one system clock.
interface ief_link_if;
    logic frame_start;
    logic sda_s;
    logic scl_rise;
    logic ninth_rise;
    logic last_rise;
    logic ack_slot;
    modport edge_end (input frame_start, output sda_s, scl_rise, ninth_rise, last_rise, ack_slot);
    modport flag_end (output frame_start, input sda_s, scl_rise, ninth_rise, last_rise, ack_slot);
endinterface : ief_link_if

// File: rtl/ief_link_edge.sv
// Serial clock and data synchronisers with a fall counter and a rise counter per frame.
// Assumes the serial clock is far slower than the system clock.
module ief_link_edge (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    ief_link_if.edge_end lnk
);
    import ief_pkg::*;

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic scl_d;
        logic [3:0] falls;
        logic [3:0] rises;
    } ief_edge_st_t;

    ief_edge_st_t st_r;
    ief_edge_st_t st_nxt;
    logic rise;
    logic fall;

    // Edges are judged only on the second synchroniser stage.
    assign rise = st_r.scl_sy[1] & ~st_r.scl_d;
    assign fall = ~st_r.scl_sy[1] & st_r.scl_d;
    assign lnk.sda_s = st_r.sda_sy[1];
    assign lnk.scl_rise = rise;
    assign lnk.ninth_rise = rise & (st_r.falls == IEF_ACK_FALLS);
    assign lnk.last_rise = rise & (st_r.rises == IEF_LAST_RISES - 4'h1);
    assign lnk.ack_slot = (st_r.falls == IEF_ACK_FALLS);

    // Counters restart with each frame so the ack slot lines up with the ninth clock.
    always_comb begin
        st_nxt = st_r;
        st_nxt.scl_sy = {st_r.scl_sy[0], scl_i};
        st_nxt.sda_sy = {st_r.sda_sy[0], sda_i};
        st_nxt.scl_d = st_r.scl_sy[1];
        if (lnk.frame_start) begin
            st_nxt.falls = 4'h0;
            st_nxt.rises = 4'h0;
        end else begin
            if (fall) begin
                st_nxt.falls = (st_r.falls == IEF_ACK_FALLS) ? 4'h0 : st_r.falls + 4'h1;
            end
            if (rise) begin
                st_nxt.rises = (st_r.falls == IEF_ACK_FALLS) ? 4'h0 : st_r.rises + 4'h1;
            end
        end
    end

    // Idle bus lines are high, so the synchronisers reset to one.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_d: 1'b1, falls: 4'h0, rises: 4'h0};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : ief_link_edge

// File: rtl/ief_top.sv
// Interrupt enables, acknowledge control and transmit/receive flags of a two-wire serial interface.
// Assumes the bus engine on the same clock supplies load, start and byte events, and the other flags.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
module ief_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic sync_format_i,
    input wire logic transmit_select_i,
    input wire logic frame_start_i,
    input wire logic tx_load_i,
    input wire logic start_issued_i,
    input wire logic slave_rx_to_tx_i,
    input wire logic rx_byte_done_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic no_ack_flag_i,
    input wire logic arb_lost_flag_i,
    input wire logic rx_lost_byte_flag_i,
    input wire logic stop_flag_i,
    output logic [7:0] tx_buffer_o,
    output logic halt_transfer_o,
    output logic tx_empty_irq_request_o,
    output logic tx_done_irq_request_o,
    output logic rx_full_irq_request_o,
    output logic overrun_irq_request_o,
    output logic nack_irq_request_o,
    output logic stop_irq_request_o,
    output logic irq_o
);
    import ief_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic tx_buffer_empty;
        logic transmit_end;
        logic rx_buffer_full;
        logic [2:0] seen;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic trs_d;
        logic halt;
        logic sda_oe;
        logic [IEF_NREQ-1:0] req;
        logic [IEF_NREQ-1:0] sts;
        logic [IEF_NREQ-1:0] ien;
        logic irq;
    } ief_st_t;

    ief_st_t st_r;
    ief_st_t st_nxt;
    ief_link_if lnk ();
    logic [7:0] flags_view;
    logic wr_go;
    logic rd_go;
    logic tx_buffer_empty_set;
    logic transmit_end_set;
    logic rx_buffer_full_set;

    // ------------------------------------------------------------------
    // Serial clock edges
    // ------------------------------------------------------------------
    assign lnk.frame_start = frame_start_i;

    ief_link_edge u_edge (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lnk(lnk)
    );

    // A request is acted on only in the cycle the master sees waitrequest low.
    assign wr_go = st_r.ack & avs_write_i;
    assign rd_go = st_r.ack & avs_read_i;

    // Live view of the status flags; the other flags are owned elsewhere.
    always_comb begin
        flags_view = IEF_RST_BYTE;
        flags_view[IEF_B_TX_BUFFER_EMPTY] = st_r.tx_buffer_empty;
        flags_view[IEF_B_TRANSMIT_END] = st_r.transmit_end;
        flags_view[IEF_B_RX_BUFFER_FULL] = st_r.rx_buffer_full;
        flags_view[IEF_B_NO_ACK_FLAG] = no_ack_flag_i;
        flags_view[IEF_B_STOPF] = stop_flag_i;
        flags_view[IEF_B_ALOVE] = arb_lost_flag_i | rx_lost_byte_flag_i;
    end

    // Setting events of the three flags kept here.
    assign tx_buffer_empty_set = tx_load_i | (transmit_select_i & ~st_r.trs_d) | start_issued_i | slave_rx_to_tx_i;
    assign transmit_end_set = sync_format_i ? lnk.last_rise : (lnk.ninth_rise & st_r.tx_buffer_empty);
    assign rx_buffer_full_set = rx_byte_done_i;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.trs_d = transmit_select_i;

        // Waitrequest drops for exactly one cycle per request.
        st_nxt.ack = (avs_read_i | avs_write_i) & ~st_r.ack;
        if ((avs_read_i | avs_write_i) & ~st_r.ack) begin
            st_nxt.rdata = 32'h0000_0000;
            if (avs_read_i) begin
                unique case (avs_address_i)
                    IEF_OFS_CTRL: st_nxt.rdata[7:0] = st_r.ctrl;
                    IEF_OFS_FLAGS: st_nxt.rdata[7:0] = flags_view;
                    IEF_OFS_TXBUF: st_nxt.rdata[7:0] = st_r.tx_buf;
                    IEF_OFS_RXBUF: st_nxt.rdata[7:0] = st_r.rx_buf;
                    IEF_OFS_ISTAT: st_nxt.rdata[IEF_NREQ-1:0] = st_r.sts;
                    IEF_OFS_IEN: st_nxt.rdata[IEF_NREQ-1:0] = st_r.ien;
                    default: st_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Control register; the received-ack bit ignores software writes.
        if (wr_go && avs_address_i == IEF_OFS_CTRL) begin
            st_nxt.ctrl = avs_writedata_i[7:0];
            st_nxt.ctrl[IEF_B_RX_ACK_BIT] = st_r.ctrl[IEF_B_RX_ACK_BIT];
        end

        // Capture the peer's ack at the ninth rise while transmitting.
        if (transmit_select_i && lnk.ninth_rise) begin
            st_nxt.ctrl[IEF_B_RX_ACK_BIT] = lnk.sda_s;
        end

        // Judged ack: a one halts continuous transfer only when selected.
        st_nxt.halt = st_nxt.ctrl[IEF_B_ACK_JUDGE_SELECT] & st_nxt.ctrl[IEF_B_RX_ACK_BIT];

        // Open drain: enable the pull-down to send a zero in the ack slot.
        st_nxt.sda_oe = ~transmit_select_i & ~sync_format_i & lnk.ack_slot & ~st_r.ctrl[IEF_B_TX_ACK_BIT];

        // A status read that sees a one arms that flag's zero-write clear.
        if (rd_go && avs_address_i == IEF_OFS_FLAGS) begin
            st_nxt.seen = st_r.seen | {st_r.tx_buffer_empty, st_r.transmit_end, st_r.rx_buffer_full};
        end

        // Clearing: zero-write after a read of one, or a buffer access.
        if (wr_go && avs_address_i == IEF_OFS_FLAGS) begin
            if (!avs_writedata_i[IEF_B_TX_BUFFER_EMPTY] && st_r.seen[2]) begin
                st_nxt.tx_buffer_empty = 1'b0;
            end
            if (!avs_writedata_i[IEF_B_TRANSMIT_END] && st_r.seen[1]) begin
                st_nxt.transmit_end = 1'b0;
            end
            if (!avs_writedata_i[IEF_B_RX_BUFFER_FULL] && st_r.seen[0]) begin
                st_nxt.rx_buffer_full = 1'b0;
            end
        end
        if (wr_go && avs_address_i == IEF_OFS_TXBUF) begin
            st_nxt.tx_buf = avs_writedata_i[7:0];
            st_nxt.tx_buffer_empty = 1'b0;
            st_nxt.transmit_end = 1'b0;
        end
        if (rd_go && avs_address_i == IEF_OFS_RXBUF) begin
            st_nxt.rx_buffer_full = 1'b0;
        end

        // Setting comes last so an event in a clearing cycle is kept.
        if (tx_buffer_empty_set) begin
            st_nxt.tx_buffer_empty = 1'b1;
        end
        if (transmit_end_set) begin
            st_nxt.transmit_end = 1'b1;
        end
        if (rx_buffer_full_set) begin
            st_nxt.rx_buffer_full = 1'b1;
            st_nxt.rx_buf = rx_byte_i;
        end

        // A cleared flag disarms its zero-write clear for the next round.
        if (!st_nxt.tx_buffer_empty) begin
            st_nxt.seen[2] = 1'b0;
        end
        if (!st_nxt.transmit_end) begin
            st_nxt.seen[1] = 1'b0;
        end
        if (!st_nxt.rx_buffer_full) begin
            st_nxt.seen[0] = 1'b0;
        end

        // Interrupt requests are levels that fall as soon as flag or enable drops.
        st_nxt.req[IEF_RQ_TXE] = st_nxt.ctrl[IEF_B_TIE] & st_nxt.tx_buffer_empty;
        st_nxt.req[IEF_RQ_TXD] = st_nxt.ctrl[IEF_B_TX_DONE_IRQ_EN] & st_nxt.transmit_end;
        st_nxt.req[IEF_RQ_RXF] = st_nxt.ctrl[IEF_B_RIE] & st_nxt.rx_buffer_full;
        st_nxt.req[IEF_RQ_OVR] = sync_format_i & rx_lost_byte_flag_i
            & (st_nxt.ctrl[IEF_B_RIE] | st_nxt.ctrl[IEF_B_NACK_IRQ_EN]);
        st_nxt.req[IEF_RQ_NAK] = st_nxt.ctrl[IEF_B_NACK_IRQ_EN] & (no_ack_flag_i | arb_lost_flag_i);
        st_nxt.req[IEF_RQ_STP] = st_nxt.ctrl[IEF_B_STOP_IRQ_EN] & stop_flag_i;

        // Sticky status: a live request wins over a clear in the same cycle.
        if (wr_go && avs_address_i == IEF_OFS_ICLR) begin
            st_nxt.sts = st_r.sts & ~avs_writedata_i[IEF_NREQ-1:0];
        end
        st_nxt.sts = st_nxt.sts | st_r.req;
        if (wr_go && avs_address_i == IEF_OFS_IEN) begin
            st_nxt.ien = avs_writedata_i[IEF_NREQ-1:0];
        end
        st_nxt.irq = |(st_nxt.sts & st_nxt.ien);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Every output except sda_o, which is tied to zero, comes straight from the state register.
    assign avs_readdata_o = st_r.rdata;
    assign avs_waitrequest_o = ~st_r.ack;
    assign sda_o = 1'b0;
    assign sda_oe_o = st_r.sda_oe;
    assign tx_buffer_o = st_r.tx_buf;
    assign halt_transfer_o = st_r.halt;
    assign tx_empty_irq_request_o = st_r.req[IEF_RQ_TXE];
    assign tx_done_irq_request_o = st_r.req[IEF_RQ_TXD];
    assign rx_full_irq_request_o = st_r.req[IEF_RQ_RXF];
    assign overrun_irq_request_o = st_r.req[IEF_RQ_OVR];
    assign nack_irq_request_o = st_r.req[IEF_RQ_NAK];
    assign stop_irq_request_o = st_r.req[IEF_RQ_STP];
    assign irq_o = st_r.irq;
endmodule : ief_top

// File: verification/ief_chk.sv
// Port-level checker of the interrupt-enable and status-flag block.
// Assumes it is bound to ief_top and sees that module's ports only.
module ief_chk
    import ief_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic avs_waitrequest_o,
    input wire logic sync_format_i,
    input wire logic transmit_select_i,
    input wire logic tx_load_i,
    input wire logic start_issued_i,
    input wire logic slave_rx_to_tx_i,
    input wire logic rx_byte_done_i,
    input wire logic no_ack_flag_i,
    input wire logic arb_lost_flag_i,
    input wire logic rx_lost_byte_flag_i,
    input wire logic stop_flag_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic halt_transfer_o,
    input wire logic tx_empty_irq_request_o,
    input wire logic tx_done_irq_request_o,
    input wire logic rx_full_irq_request_o,
    input wire logic overrun_irq_request_o,
    input wire logic nack_irq_request_o,
    input wire logic stop_irq_request_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // A bus access completes at the edge where waitrequest is seen low.
    logic acc;
    assign acc = (avs_read_i | avs_write_i) & !avs_waitrequest_o;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    bus_answer_a: assert property ((avs_read_i | avs_write_i) & avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus request not answered");
    ovr_gate_a: assert property (!(sync_format_i & rx_lost_byte_flag_i) |=> !overrun_irq_request_o)
        else $error("overrun request without cause");
    nak_gate_a: assert property (!(no_ack_flag_i | arb_lost_flag_i) |=> !nack_irq_request_o)
        else $error("no-ack request without cause");
    stop_gate_a: assert property (!stop_flag_i |=> !stop_irq_request_o)
        else $error("stop request without cause");
    ack_drive_a: assert property ($rose(sda_oe_o) |-> !$past(transmit_select_i) && !$past(sync_format_i) && !sda_o)
        else $error("data line driven outside receive mode");
    txbuf_clear_a: assert property (acc & avs_write_i & (avs_address_i == IEF_OFS_TXBUF) & !tx_load_i
        & !start_issued_i & !slave_rx_to_tx_i |-> ##2 !tx_empty_irq_request_o & !tx_done_irq_request_o)
        else $error("transmit requests stay after buffer write");
    rxbuf_clear_a: assert property (acc & avs_read_i & (avs_address_i == IEF_OFS_RXBUF) & !rx_byte_done_i
        |-> ##2 !rx_full_irq_request_o)
        else $error("receive request stays after buffer read");
    halt_off_a: assert property (acc & avs_write_i & (avs_address_i == IEF_OFS_CTRL) & !avs_writedata_i[2]
        |-> ##2 !halt_transfer_o)
        else $error("halt without acknowledge judgement");
endmodule : ief_chk

bind ief_top ief_chk u_chk (.*);

// File: verification/ief_peer.sv
// Two-wire bus peer: start, nine-bit frame and stop with a 160 ns serial clock.
// Assumes a pull-up on the data line; the clock stands high between frames.
module ief_peer (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ack_seen;
    // Idle bus: both lines released high.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        ack_seen = 1'b0;
    end
    // The small offset keeps the start condition's edges off the system clock grid.
    task automatic start_cond();
        #3;
        sda_low_o = 1'b1;
        #80;
        scl_o = 1'b0;
        #80;
    endtask : start_cond
    // A bit of 1 releases the line; the data line is sampled mid high phase.
    task automatic xfer(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_low_o = !b[i];
            #40;
            scl_o = 1'b1;
            #40;
            ack_seen = sda_i;
            #40;
            scl_o = 1'b0;
            #40;
        end
    endtask : xfer
    task automatic stop_cond();
        sda_low_o = 1'b1;
        #80;
        scl_o = 1'b1;
        #80;
        sda_low_o = 1'b0;
        #80;
    endtask : stop_cond
endmodule : ief_peer

// File: verification/tb_i2c_irq_enable_status_flags.sv
// Self-checking bench of the flag block: register tasks, event pulses and serial frames.
// Assumes the peer model and the bound checker; the link clock only runs within frames.
module tb_i2c_irq_enable_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import ief_pkg::*;
    logic clk, rst_n, rd, wr, wrq, scl, pdrv, sda, sda_oe, sda_q, halt, irq;
    logic sync_f, tsel, nak, arb, ovr_f, stp;
    logic [4:0] adr, ev;
    logic [31:0] wd, rdat, seed, got;
    logic [7:0] rxb, txb, txo;
    logic [5:0] req;
    int bad_count, num_checks;
    // Wired-AND data line with a pull-up.
    assign sda = !(pdrv | (sda_oe & !sda_q));
    ief_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_q), .sda_oe_o(sda_oe), .sync_format_i(sync_f), .transmit_select_i(tsel),
        .frame_start_i(ev[4]), .tx_load_i(ev[0]), .start_issued_i(ev[1]), .slave_rx_to_tx_i(ev[2]),
        .rx_byte_done_i(ev[3]), .rx_byte_i(rxb), .no_ack_flag_i(nak), .arb_lost_flag_i(arb),
        .rx_lost_byte_flag_i(ovr_f), .stop_flag_i(stp), .tx_buffer_o(txo), .halt_transfer_o(halt),
        .tx_empty_irq_request_o(req[0]), .tx_done_irq_request_o(req[1]), .rx_full_irq_request_o(req[2]),
        .overrun_irq_request_o(req[3]), .nack_irq_request_o(req[4]), .stop_irq_request_o(req[5]), .irq_o(irq));
    ief_peer peer (.scl_o(scl), .sda_low_o(pdrv), .sda_i(sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr
    // The received acknowledge bit is read-only, so writes never reach it.
    function automatic logic [31:0] ctrl_exp(input logic [7:0] w, input logic a);
        return {24'h0, w[7:2], a, w[0]};
    endfunction : ctrl_exp
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One Avalon access, held until the edge that sees waitrequest low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wrq !== 1'b0 && n < 50);
        if (wrq !== 1'b0) begin
            bad_count++;
            final_report();
        end
        @(posedge clk);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(nm, got, exp);
    endtask : rchk
    task automatic fire(input int i);
        @(posedge clk);
        ev <= 5'h1 << i;
        @(posedge clk);
        ev <= 5'h0;
    endtask : fire
    task automatic frame(input logic [8:0] b);
        peer.start_cond();
        fire(4);
        peer.xfer(b);
        repeat (6) @(posedge clk);
    endtask : frame
    task automatic lvl(input logic [4:0] l, input logic [7:0] c, input logic [2:0] e);
        {sync_f, nak, arb, ovr_f, stp} <= l;
        bus(1'b1, IEF_OFS_CTRL, {24'h0, c});
        repeat (3) @(posedge clk);
        check("stop nack overrun requests", {29'h0, req[5:3]}, {29'h0, e});
    endtask : lvl
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, rd, wr, sync_f, tsel, nak, arb, ovr_f, stp} = 9'h0;
        {adr, ev, wd, rxb} = 50'h0;
        seed = 32'hc4c0;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rchk("ctrl", IEF_OFS_CTRL, 32'h0);
        rchk("flags", IEF_OFS_FLAGS, 32'h0);
        rchk("unmapped", 5'h1c, 32'h0);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            bus(1'b1, IEF_OFS_CTRL, seed);
            rchk("ctrl", IEF_OFS_CTRL, ctrl_exp(seed[7:0], 1'b0));
        end
        $display("test registers done");
        bus(1'b1, IEF_OFS_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            if (i == 3)
                tsel <= 1'b1;
            else
                fire(i);
            bus(1'b1, IEF_OFS_FLAGS, 32'h0);
            rchk("tx empty kept", IEF_OFS_FLAGS, 32'h80);
            bus(1'b1, IEF_OFS_FLAGS, 32'h0);
            rchk("tx empty cleared", IEF_OFS_FLAGS, 32'h0);
        end
        tsel <= 1'b0;
        bus(1'b1, IEF_OFS_CTRL, 32'hc0);
        fire(0);
        repeat (3) @(posedge clk);
        check("txe request", req[IEF_RQ_TXE], 32'h1);
        seed = lfsr(seed);
        txb = seed[7:0];
        bus(1'b1, IEF_OFS_TXBUF, {24'h0, txb});
        repeat (3) @(posedge clk);
        check("tx buffer", txo, txb);
        check("txe request", req[IEF_RQ_TXE], 32'h0);
        $display("test transmit empty done");
        bus(1'b1, IEF_OFS_IEN, 32'h04);
        bus(1'b1, IEF_OFS_CTRL, 32'h20);
        rxb <= seed[15:8];
        fire(3);
        repeat (3) @(posedge clk);
        check("rxf request", req[IEF_RQ_RXF], 32'h1);
        check("irq", irq, 32'h1);
        rchk("flags", IEF_OFS_FLAGS, 32'h20);
        rchk("rx buffer", IEF_OFS_RXBUF, {24'h0, seed[15:8]});
        rchk("flags", IEF_OFS_FLAGS, 32'h0);
        rchk("irq status", IEF_OFS_ISTAT, 32'h05);
        bus(1'b1, IEF_OFS_ICLR, 32'h3f);
        repeat (2) @(posedge clk);
        check("irq", irq, 32'h0);
        $display("test receive full done");
        lvl(5'b01000, 8'h10, 3'b010);
        lvl(5'b01000, 8'h00, 3'b000);
        lvl(5'b00100, 8'h10, 3'b010);
        lvl(5'b10010, 8'h10, 3'b001);
        lvl(5'b10010, 8'h20, 3'b001);
        lvl(5'b00010, 8'h30, 3'b000);
        lvl(5'b00001, 8'h08, 3'b100);
        check("irq masked", irq, 32'h0);
        lvl(5'b00001, 8'h00, 3'b000);
        // Drop every outside flag again, so the status reads of the frame tests see only the flags kept here.
        lvl(5'b00000, 8'h00, 3'b000);
        $display("test request gating done");
        tsel <= 1'b1;
        for (int a = 1; a >= 0; a--) begin
            fire(1);
            bus(1'b1, IEF_OFS_CTRL, 32'h44);
            frame({8'hff, a[0]});
            rchk("ctrl", IEF_OFS_CTRL, ctrl_exp(8'h44, a[0]));
            check("halt", halt, a);
            rchk("flags", IEF_OFS_FLAGS, 32'hc0);
            check("txd request", req[IEF_RQ_TXD], 32'h1);
            bus(1'b1, IEF_OFS_TXBUF, 32'h0);
            rchk("flags", IEF_OFS_FLAGS, 32'h0);
            peer.stop_cond();
        end
        // Synchronous format ends a transmit frame on its last data bit, without the empty flag.
        @(posedge clk);
        sync_f <= 1'b1;
        frame(9'h1ff);
        rchk("flags", IEF_OFS_FLAGS, 32'h40);
        sync_f <= 1'b0;
        bus(1'b1, IEF_OFS_TXBUF, 32'h0);
        peer.stop_cond();
        @(posedge clk);
        tsel <= 1'b0;
        for (int a = 0; a < 2; a++) begin
            seed = lfsr(seed);
            bus(1'b1, IEF_OFS_CTRL, a);
            frame({seed[7:0], 1'b1});
            check("ack driven", peer.ack_seen, a);
            peer.stop_cond();
        end
        $display("test serial frames done");
        final_report();
    end
endmodule : tb_i2c_irq_enable_status_flags
